// >>> design/rtcc_core.v
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/100ps
`include "rtcc_defines.vh"

module rtcc_core #(
  parameter DIV_TOP = `RTCC_XTAL_HZ
) (
  input  wire       clock,
  input  wire       reset,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_write,
  input  wire       reg_read,
  output reg  [7:0] reg_rdata,
  input  wire       xtal_clock_in,
  input  wire       battery_test_input_n,
  input  wire       well_reset_input_n,
  input  wire       event_timer_on_line8,
  output reg        irq_to_apic,
  output reg        irq_to_legacy,
  output reg        update_in_progress_flag,
  output reg        battery_power_status_flag,
  output reg        upper_range_lock,
  output reg        lower_range_lock,
  output reg  [2:0] sleep_type_field,
  output reg        wake_enable
);

  // ************************************************************
  // timing
  // ************************************************************
  localparam integer BUSY_LEAD  = (`RTCC_BUSY_LEAD_MS * DIV_TOP + 999) / 1000;
  localparam [31:0]  DIV_LAST_W = DIV_TOP - 1;
  localparam [31:0]  BUSY_W     = DIV_TOP - BUSY_LEAD;
  localparam [14:0]  DIV_LAST   = DIV_LAST_W[14:0];
  localparam [14:0]  BUSY_START = BUSY_W[14:0];
  localparam         ST_IDLE   = 1'b0;
  localparam         ST_UPDATE = 1'b1;

  // ************************************************************
  // storage
  // ************************************************************
  reg  [7:0]  ram [0:127];
  reg  [7:0]  ctrl_a;
  reg  [7:0]  ctrl_b;
  reg  [2:0]  flags;
  reg  [7:0]  well_cfg;
  reg  [14:0] div_count;
  reg         state;
  reg  [2:0]  xtal_sync;
  reg         xtal_level;
  reg  [2:0]  batt_sync;
  reg  [2:0]  wrst_sync;
  reg         wrst_active;
  integer     k;

  wire       div_valid   = (ctrl_a[`RTCC_A_DIV_HI:`RTCC_A_DIV_LO] == `RTCC_DIV_VALID);
  wire       set_inhibit = ctrl_b[`RTCC_B_SET];
  wire       bin_mode    = ctrl_b[`RTCC_B_BINARY];
  wire       h24_mode    = ctrl_b[`RTCC_B_H24];
  wire [3:0] rate_sel    = ctrl_a[`RTCC_A_RATE_HI:`RTCC_A_RATE_LO];
  wire       xtal_tick   = (xtal_sync[2] == xtal_sync[1]) && xtal_sync[2] && !xtal_level;
  wire       sec_wrap    = xtal_tick && div_valid && (div_count == DIV_LAST);
  wire       in_ram      = !reg_addr[7];
  wire       time_byte   = (reg_addr < `RTCC_OFS_CTRL_A);
  wire       ctrl_byte   = time_byte || (reg_addr <= `RTCC_OFS_CTRL_D);
  wire [14:0] rate_mask  = (15'h0001 << (rate_sel - 4'h1)) - 15'h0001;
  wire       periodic_ev = xtal_tick && div_valid && (rate_sel != 4'h0) &&
                           ((div_count & rate_mask) == rate_mask);
  wire       irqf        = (flags[2] & ctrl_b[`RTCC_B_PIE]) |
                           (flags[1] & ctrl_b[`RTCC_B_AIE]) |
                           (flags[0] & ctrl_b[`RTCC_B_UIE]);
  wire       range_hit_lo = in_ram && !reg_addr[6] && (reg_addr[5:3] == 3'h7);
  wire       range_hit_up = in_ram && reg_addr[6] && (reg_addr[5:3] == 3'h7);
  wire       locked_hit  = (range_hit_lo && lower_range_lock) ||
                           (range_hit_up && upper_range_lock);

  // ************************************************************
  // encoding helpers
  // ************************************************************
  function [7:0] to_bin;
    input [7:0] v;
    input       bin;
    begin
      to_bin = bin ? v : ({4'h0, v[7:4]} * 8'h0a + {4'h0, v[3:0]});
    end
  endfunction

  function [7:0] from_bin;
    input [7:0] v;
    input       bin;
    reg   [7:0] tens;
    begin
      tens = v / 8'h0a;
      from_bin = bin ? v : {tens[3:0], 4'h0} | (v - tens * 8'h0a);
    end
  endfunction

  function [7:0] month_days;
    input [7:0] mon;
    input [7:0] yr;
    begin
      case (mon)
        8'h02: month_days = (yr[1:0] == 2'h0) ? 8'h1d : 8'h1c;
        8'h04, 8'h06, 8'h09, 8'h0b: month_days = 8'h1e;
        default: month_days = 8'h1f;
      endcase
    end
  endfunction

  function alarm_match;
    input [7:0] alm;
    input [7:0] now;
    begin
      alarm_match = (alm[7:6] == `RTCC_ALM_DONT_CARE) || (alm == now);
    end
  endfunction

  // ************************************************************
  // next time and date, one combinational pass
  // ************************************************************
  reg [7:0] b_sec, b_min, b_hr, b_dow, b_dom, b_mon, b_yr;
  reg [7:0] hr12;
  reg [7:0] next_sec, next_min, next_hour, next_dow, next_dom, next_mon, next_year;
  reg       alarm_hit;
  reg [7:0] hr_code;

  always @* begin
    hr_code = 8'h00;
    b_sec = to_bin(ram[0], bin_mode);
    b_min = to_bin(ram[2], bin_mode);
    b_dow = to_bin(ram[6], bin_mode);
    b_dom = to_bin(ram[7], bin_mode);
    b_mon = to_bin(ram[8], bin_mode);
    b_yr  = to_bin(ram[9], bin_mode);
    hr12  = to_bin({1'b0, ram[4][6:0]}, bin_mode);
    if (h24_mode) begin
      b_hr = to_bin(ram[4], bin_mode);
    end else begin
      b_hr = ((hr12 == 8'h0c) ? 8'h00 : hr12) + (ram[4][7] ? 8'h0c : 8'h00);
    end
    if (b_sec >= 8'h3b) begin
      b_sec = 8'h00;
      if (b_min >= 8'h3b) begin
        b_min = 8'h00;
        if (b_hr >= 8'h17) begin
          b_hr  = 8'h00;
          b_dow = (b_dow >= 8'h07) ? 8'h01 : b_dow + 8'h01;
          if (b_dom >= month_days(b_mon, b_yr)) begin
            b_dom = 8'h01;
            if (b_mon >= 8'h0c) begin
              b_mon = 8'h01;
              b_yr  = (b_yr >= 8'h63) ? 8'h00 : b_yr + 8'h01;
            end else begin
              b_mon = b_mon + 8'h01;
            end
          end else begin
            b_dom = b_dom + 8'h01;
          end
        end else begin
          b_hr = b_hr + 8'h01;
        end
      end else begin
        b_min = b_min + 8'h01;
      end
    end else begin
      b_sec = b_sec + 8'h01;
    end
    next_sec  = from_bin(b_sec, bin_mode);
    next_min  = from_bin(b_min, bin_mode);
    next_dow  = from_bin(b_dow, bin_mode);
    next_dom  = from_bin(b_dom, bin_mode);
    next_mon  = from_bin(b_mon, bin_mode);
    next_year = from_bin(b_yr, bin_mode);
    if (h24_mode) begin
      next_hour = from_bin(b_hr, bin_mode);
    end else begin
      hr12 = (b_hr >= 8'h0c) ? b_hr - 8'h0c : b_hr;
      hr12 = (hr12 == 8'h00) ? 8'h0c : hr12;
      hr_code   = from_bin(hr12, bin_mode);
      next_hour = {(b_hr >= 8'h0c), hr_code[6:0]};
    end
    alarm_hit = alarm_match(ram[1], next_sec) && alarm_match(ram[3], next_min) &&
                alarm_match(ram[5], next_hour);
  end

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  always @(posedge clock) begin
    if (reset) begin
      xtal_sync   <= 3'h0;
      xtal_level  <= 1'b0;
      batt_sync   <= 3'h7;
      wrst_sync   <= 3'h7;
      wrst_active <= 1'b0;
    end else begin
      xtal_sync <= {xtal_sync[1:0], xtal_clock_in};
      batt_sync <= {batt_sync[1:0], battery_test_input_n};
      wrst_sync <= {wrst_sync[1:0], well_reset_input_n};
      if (xtal_sync[2] == xtal_sync[1]) begin
        xtal_level <= xtal_sync[2];
      end
      if (wrst_sync[2] == wrst_sync[1]) begin
        wrst_active <= !wrst_sync[2];
      end
    end
  end

  // ************************************************************
  // divider chain and update sequencer
  // ************************************************************
  always @(posedge clock) begin
    if (reset || wrst_active) begin
      div_count               <= 15'h0000;
      state                   <= ST_IDLE;
      update_in_progress_flag <= 1'b0;
    end else begin
      if (!div_valid) begin
        div_count <= 15'h0000;
      end else if (xtal_tick) begin
        div_count <= (div_count == DIV_LAST) ? 15'h0000 : div_count + 15'h0001;
      end
      case (state)
        ST_IDLE: begin
          if (sec_wrap && !set_inhibit) begin
            state <= ST_UPDATE;
          end
          // raised BUSY_LEAD crystal ticks before the rollover
          update_in_progress_flag <= div_valid && !set_inhibit &&
                                     (div_count >= BUSY_START);
        end
        ST_UPDATE: begin
          // one clock of writeback, far inside the update time limit
          state                   <= ST_IDLE;
          update_in_progress_flag <= 1'b0;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // CMOS RAM and time bytes
  // ************************************************************
  always @(posedge clock) begin
    if (reset) begin
      for (k = 0; k < 128; k = k + 1) begin
        ram[k] <= 8'h00;
      end
    end else begin
      if (state == ST_UPDATE) begin
        ram[0] <= next_sec;
        ram[2] <= next_min;
        ram[4] <= next_hour;
        ram[6] <= next_dow;
        ram[7] <= next_dom;
        ram[8] <= next_mon;
        ram[9] <= next_year;
      end
      // later assignment: a colliding host write replaces the update value
      if (reg_write && in_ram && !locked_hit && (!ctrl_byte || time_byte)) begin
        ram[reg_addr[6:0]] <= reg_wdata;
      end
    end
  end

  // ************************************************************
  // control, status, locks and well bits
  // ************************************************************
  always @(posedge clock) begin
    if (reset || wrst_active) begin
      ctrl_a   <= `RTCC_A_RESET;
      ctrl_b   <= `RTCC_B_RESET;
      flags    <= 3'h0;
      well_cfg <= `RTCC_WCFG_RESET;
    end else begin
      if (reg_write && reg_addr == `RTCC_OFS_CTRL_A) begin
        ctrl_a <= {1'b0, reg_wdata[6:0]};
      end
      if (reg_write && reg_addr == `RTCC_OFS_CTRL_B) begin
        ctrl_b <= reg_wdata;
      end
      if (reg_write && reg_addr == `RTCC_OFS_WELL_CFG) begin
        well_cfg <= reg_wdata;
      end
      // reading status clears the flags; a new event in that cycle survives
      // bit 2 periodic, bit 1 alarm, bit 0 update ended
      flags <= ((reg_read && reg_addr == `RTCC_OFS_CTRL_C) ? 3'h0 : flags) |
               {periodic_ev, (state == ST_UPDATE) && alarm_hit,
                (state == ST_UPDATE)};
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      lower_range_lock          <= 1'b0;
      upper_range_lock          <= 1'b0;
      battery_power_status_flag <= 1'b0;
    end else begin
      if (reg_write && reg_addr == `RTCC_OFS_LOCK) begin
        lower_range_lock <= lower_range_lock | reg_wdata[`RTCC_LOCK_LOWER];
        upper_range_lock <= upper_range_lock | reg_wdata[`RTCC_LOCK_UPPER];
      end
      // battery test held low sets the flag; writing one clears it, set wins
      if ((batt_sync[2] == batt_sync[1]) && !batt_sync[2]) begin
        battery_power_status_flag <= 1'b1;
      end else if (reg_write && reg_addr == `RTCC_OFS_PWR_STS &&
                   reg_wdata[`RTCC_PWR_BATT]) begin
        battery_power_status_flag <= 1'b0;
      end
    end
  end

  // ************************************************************
  // interrupt line and well outputs
  // ************************************************************
  always @(posedge clock) begin
    if (reset) begin
      irq_to_apic      <= 1'b0;
      irq_to_legacy    <= 1'b0;
      sleep_type_field <= 3'h0;
      wake_enable      <= 1'b0;
    end else begin
      // line 8 from the serial stream has no path in here
      irq_to_apic      <= irqf && !event_timer_on_line8;
      irq_to_legacy    <= irqf && !event_timer_on_line8;
      sleep_type_field <= well_cfg[2:0];
      wake_enable      <= well_cfg[`RTCC_WCFG_WAKE];
    end
  end

  // ************************************************************
  // read port, never gated by idle states
  // ************************************************************
  always @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      if (locked_hit) begin
        reg_rdata <= `RTCC_LOCKED_READ;
      end else if (time_byte && state == ST_UPDATE) begin
        reg_rdata <= `RTCC_LOCKED_READ;
      end else if (reg_addr == `RTCC_OFS_CTRL_A) begin
        reg_rdata <= {update_in_progress_flag, ctrl_a[6:0]};
      end else if (reg_addr == `RTCC_OFS_CTRL_B) begin
        reg_rdata <= ctrl_b;
      end else if (reg_addr == `RTCC_OFS_CTRL_C) begin
        reg_rdata <= {irqf, flags[2:0], 4'h0};
      end else if (reg_addr == `RTCC_OFS_CTRL_D) begin
        reg_rdata <= `RTCC_D_VALUE;
      end else if (in_ram) begin
        reg_rdata <= ram[reg_addr[6:0]];
      end else if (reg_addr == `RTCC_OFS_LOCK) begin
        reg_rdata <= {6'h00, upper_range_lock, lower_range_lock};
      end else if (reg_addr == `RTCC_OFS_WELL_CFG) begin
        reg_rdata <= well_cfg;
      end else if (reg_addr == `RTCC_OFS_PWR_STS) begin
        reg_rdata <= {7'h00, battery_power_status_flag};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule

// >>> design/rtcc_defines.vh
`ifndef RTCC_DEFINES_VH
`define RTCC_DEFINES_VH

// ************************************************************
// register offsets
// ************************************************************
`define RTCC_OFS_SEC        8'h00
`define RTCC_OFS_SEC_ALM    8'h01
`define RTCC_OFS_MIN        8'h02
`define RTCC_OFS_MIN_ALM    8'h03
`define RTCC_OFS_HOUR       8'h04
`define RTCC_OFS_HOUR_ALM   8'h05
`define RTCC_OFS_DOW        8'h06
`define RTCC_OFS_DOM        8'h07
`define RTCC_OFS_MON        8'h08
`define RTCC_OFS_YEAR       8'h09
`define RTCC_OFS_CTRL_A     8'h0a
`define RTCC_OFS_CTRL_B     8'h0b
`define RTCC_OFS_CTRL_C     8'h0c
`define RTCC_OFS_CTRL_D     8'h0d
`define RTCC_OFS_RAM_TOP    8'h7f
`define RTCC_OFS_LOCK       8'h80
`define RTCC_OFS_WELL_CFG   8'h81
`define RTCC_OFS_PWR_STS    8'h82

// ************************************************************
// locked ranges, eight bytes each
// ************************************************************
`define RTCC_LOWER_RANGE_HI 5'h07
`define RTCC_UPPER_RANGE_HI 5'h0f

// ************************************************************
// field positions
// ************************************************************
`define RTCC_A_BUSY         7
`define RTCC_A_DIV_HI       6
`define RTCC_A_DIV_LO       4
`define RTCC_A_RATE_HI      3
`define RTCC_A_RATE_LO      0
`define RTCC_B_SET          7
`define RTCC_B_PIE          6
`define RTCC_B_AIE          5
`define RTCC_B_UIE          4
`define RTCC_B_BINARY       2
`define RTCC_B_H24          1
`define RTCC_C_IRQF         7
`define RTCC_C_PF           6
`define RTCC_C_AF           5
`define RTCC_C_UF           4
`define RTCC_LOCK_LOWER     0
`define RTCC_LOCK_UPPER     1
`define RTCC_WCFG_WAKE      3
`define RTCC_PWR_BATT       0

// ************************************************************
// reset values and codes
// ************************************************************
`define RTCC_A_RESET        8'h26
`define RTCC_B_RESET        8'h02
`define RTCC_D_VALUE        8'h80
`define RTCC_WCFG_RESET     8'h00
`define RTCC_DIV_VALID      3'h2
`define RTCC_LOCKED_READ    8'hff
`define RTCC_ALM_DONT_CARE  2'h3

// ************************************************************
// timing
// ************************************************************
`define RTCC_XTAL_HZ        32768
`define RTCC_BUSY_LEAD_MS   488
`define RTCC_UPDATE_MAX_MS  1984
`define RTCC_PERIODIC_MIN_MS 122
`define RTCC_PERIODIC_MAX_MS 500

`endif

// >>> test/rtcc_core_assertions.sv
`timescale 1ns/100ps
module rtcc_core_checker (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       battery_test_input_n,
  input wire logic       well_reset_input_n,
  input wire logic       event_timer_on_line8,
  input wire logic       irq_to_apic,
  input wire logic       irq_to_legacy,
  input wire logic       update_in_progress_flag,
  input wire logic       battery_power_status_flag,
  input wire logic       upper_range_lock,
  input wire logic       lower_range_lock,
  input wire logic [2:0] sleep_type_field,
  input wire logic       wake_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // ************************************************************
  // interrupt routing
  // ************************************************************
  a_irq_paired: assert property (irq_to_apic == irq_to_legacy)
    else $error("interrupt outputs disagree");
  a_irq_blocked: assert property (event_timer_on_line8 |=> !irq_to_apic)
    else $error("interrupt not blocked by event timer");

  // ************************************************************
  // lockable ranges and control D
  // ************************************************************
  a_upper_sticky: assert property (upper_range_lock |=> upper_range_lock)
    else $error("upper lock dropped");
  a_lower_sticky: assert property (lower_range_lock |=> lower_range_lock)
    else $error("lower lock dropped");
  a_lock_cause: assert property ($rose(upper_range_lock) |->
    $past(reg_write && reg_addr == 8'h80 && reg_wdata[1]))
    else $error("upper lock set without a write");
  a_locked_read: assert property (reg_read && lower_range_lock &&
    reg_addr[7:3] == 5'h07 |=> reg_rdata == 8'hff)
    else $error("locked byte leaked");
  a_ctrl_d_value: assert property (reg_read && reg_addr == 8'h0d |=>
    reg_rdata == 8'h80)
    else $error("control D wrong");

  // ************************************************************
  // battery well
  // ************************************************************
  a_batt_sets: assert property (!battery_test_input_n [*6] |=>
    battery_power_status_flag)
    else $error("battery flag not set");
  a_batt_holds: assert property (battery_power_status_flag &&
    !(reg_write && reg_addr == 8'h82 && reg_wdata[0]) |=> battery_power_status_flag)
    else $error("battery flag lost");
  a_well_clears: assert property (!well_reset_input_n [*8] |=>
    sleep_type_field == 3'h0 && !wake_enable)
    else $error("well config not cleared");

  c_locked_read: cover property (reg_read && lower_range_lock && reg_addr == 8'h38);
  c_irq_rise: cover property ($rose(irq_to_apic));
  c_update: cover property ($fell(update_in_progress_flag));
endmodule

bind rtcc_core rtcc_core_checker rtcc_core_checker_i (
  .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .battery_test_input_n(battery_test_input_n), .well_reset_input_n(well_reset_input_n),
  .event_timer_on_line8(event_timer_on_line8), .irq_to_apic(irq_to_apic),
  .irq_to_legacy(irq_to_legacy), .update_in_progress_flag(update_in_progress_flag),
  .battery_power_status_flag(battery_power_status_flag),
  .upper_range_lock(upper_range_lock), .lower_range_lock(lower_range_lock),
  .sleep_type_field(sleep_type_field), .wake_enable(wake_enable)
);

// >>> test/rtcc_xtal_model.sv
`timescale 1ns/100ps
// scaled crystal: toggles every HALF clocks so simulated seconds stay short
module rtcc_xtal_model #(
  parameter int HALF = 4
) (
  input  wire logic clock,
  input  wire logic run,
  output logic      xtal
);
  int   cnt   = 0;
  logic level = 1'b0;
  assign xtal = level;
  always @(posedge clock) begin
    if (run) begin
      if (cnt == HALF - 1) begin
        cnt   <= 0;
        level <= ~level;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// >>> test/rtcc_core_tb.sv
`timescale 1ns/100ps
`include "rtcc_defines.vh"
module rtcc_core_tb;
  localparam int SEC_CYC = 64 * 2 * 4;
  localparam int LEAD_CYC = (64 * 488 + 999) / 1000 * 8;
  localparam int MAX_CYC = 1984 * SEC_CYC / 1000;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic       xtal_clock_in;
  logic       xtal_run = 1'b0;
  logic       battery_test_input_n = 1'b1;
  logic       well_reset_input_n = 1'b1;
  logic       event_timer_on_line8 = 1'b0;
  logic       irq_to_apic;
  logic       irq_to_legacy;
  logic       update_in_progress_flag;
  logic       battery_power_status_flag;
  logic       upper_range_lock;
  logic       lower_range_lock;
  logic [2:0] sleep_type_field;
  logic       wake_enable;
  int         errors = 0;
  int         comparisons = 0;
  int         k;
  time        t_rise;
  time        t_fall;
  time        t_prev;
  logic       lead_ok;
  logic [7:0] tset [0:9] = '{8'h3b, 8'h00, 8'h3b, 8'h00, 8'h17, 8'h00, 8'h03, 8'h1f, 8'h0c, 8'h10};
  logic [7:0] texp [0:9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h01, 8'h11};

  always #25 clock = ~clock;

  rtcc_xtal_model #(.HALF(4)) rtcc_xtal_model_i (
    .clock(clock), .run(xtal_run), .xtal(xtal_clock_in)
  );

  rtcc_core #(.DIV_TOP(64)) rtcc_core_i (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .xtal_clock_in(xtal_clock_in), .battery_test_input_n(battery_test_input_n),
    .well_reset_input_n(well_reset_input_n), .event_timer_on_line8(event_timer_on_line8),
    .irq_to_apic(irq_to_apic), .irq_to_legacy(irq_to_legacy),
    .update_in_progress_flag(update_in_progress_flag),
    .battery_power_status_flag(battery_power_status_flag),
    .upper_range_lock(upper_range_lock), .lower_range_lock(lower_range_lock),
    .sleep_type_field(sleep_type_field), .wake_enable(wake_enable)
  );

  // ************************************************************
  // bus and check tasks
  // ************************************************************
  task automatic finish_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // read data is registered on the strobe edge and held until the next read strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask
  task automatic wait_busy(input logic want);
    int n;
    n = 0;
    while (update_in_progress_flag !== want && n < 2000) begin
      settle(1);
      n = n + 1;
    end
    if (n >= 2000) begin
      errors = errors + 1;
      finish_test();
    end
  endtask
  task automatic one_update;
    wait_busy(1'b1);
    t_rise = $time;
    wait_busy(1'b0);
    t_fall = $time;
    settle(2);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    rdc(8'h0a, `RTCC_A_RESET);
    rdc(8'h0b, `RTCC_B_RESET);
    rdc(8'h0c, 8'h00);
    rdc(8'h0d, `RTCC_D_VALUE);
    rdc(8'h90, 8'h00);
    wr(8'h37, 8'h5a);
    wr(8'h38, 8'h11);
    wr(8'h7f, 8'h22);
    wr(8'h0e, 8'ha5);
    wr(8'h80, 8'h03);
    wr(8'h38, 8'h33);
    wr(8'h80, 8'h00);
    rdc(8'h80, 8'h03);
    chk({14'h0, upper_range_lock, lower_range_lock}, 16'h0003);
    rdc(8'h38, `RTCC_LOCKED_READ);
    rdc(8'h7f, `RTCC_LOCKED_READ);
    rdc(8'h37, 8'h5a);
    // year end rollover in binary 24 hour mode, alarm at midnight
    wr(8'h0b, 8'h86);
    for (k = 0; k < 10; k = k + 1) wr(k[7:0], tset[k]);
    wr(8'h0a, 8'h20);
    wr(8'h0b, 8'h26);
    @(posedge clock);
    xtal_run <= 1'b1;
    one_update();
    chk({15'h0, irq_to_apic}, 16'h0001);
    @(posedge clock);
    event_timer_on_line8 <= 1'b1;
    settle(2);
    chk({15'h0, irq_to_apic}, 16'h0000);
    @(posedge clock);
    event_timer_on_line8 <= 1'b0;
    settle(2);
    chk({15'h0, irq_to_legacy}, 16'h0001);
    rdc(8'h0c, 8'hb0);
    settle(2);
    chk({15'h0, irq_to_apic}, 16'h0000);
    for (k = 0; k < 10; k = k + 1) rdc(k[7:0], texp[k]);
    // twelve hour BCD: 1:59:59 PM becomes 2:00:00 PM
    wr(8'h0b, 8'h80);
    wr(8'h00, 8'h59);
    wr(8'h02, 8'h59);
    wr(8'h04, 8'h81);
    wr(8'h0b, 8'h00);
    one_update();
    rdc(8'h00, 8'h00);
    rdc(8'h04, 8'h82);
    t_prev = t_fall;
    one_update();
    chk(16'((t_fall - t_prev) / 50), 16'(SEC_CYC));
    lead_ok = (t_fall - t_rise) / 50 >= LEAD_CYC && (t_fall - t_rise) / 50 <= MAX_CYC;
    chk({15'h0, lead_ok}, 16'h0001);
    // set bit high, then an invalid divider: no update may run
    for (k = 0; k < 2; k = k + 1) begin
      wr(8'h0a, k ? 8'h00 : 8'h20);
      wr(8'h0b, k ? 8'h00 : 8'h80);
      wr(8'h00, 8'h07);
      settle(2 * SEC_CYC);
      rdc(8'h00, 8'h07);
    end
    wr(8'h0a, 8'h21);
    wr(8'h0b, 8'h42);
    settle(40);
    chk({15'h0, irq_to_apic}, 16'h0001);
    wr(8'h0b, 8'h02);
    settle(2);
    chk({15'h0, irq_to_apic}, 16'h0000);
    @(posedge clock);
    battery_test_input_n <= 1'b0;
    repeat (10) @(posedge clock);
    battery_test_input_n <= 1'b1;
    settle(10);
    rdc(8'h82, 8'h01);
    chk({15'h0, battery_power_status_flag}, 16'h0001);
    wr(8'h81, 8'h0d);
    settle(2);
    chk({12'h0, wake_enable, sleep_type_field}, 16'h000d);
    @(posedge clock);
    well_reset_input_n <= 1'b0;
    repeat (10) @(posedge clock);
    well_reset_input_n <= 1'b1;
    settle(10);
    chk({12'h0, wake_enable, sleep_type_field}, 16'h0000);
    rdc(8'h81, 8'h00);
    rdc(8'h82, 8'h01);
    rdc(8'h0b, `RTCC_B_RESET);
    rdc(8'h0e, 8'ha5);
    wr(8'h82, 8'h01);
    rdc(8'h82, 8'h00);
    for (k = 14; k < 128; k = k + 1) wr(k[7:0], 8'h00);
    rdc(8'h0b, `RTCC_B_RESET);
    rdc(8'h37, 8'h00);
    // only a hard reset may release the locks
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    rdc(8'h80, 8'h00);
    chk({14'h0, upper_range_lock, lower_range_lock}, 16'h0000);
    rdc(8'h38, 8'h00);
    finish_test();
  end
endmodule
